// [amp_defs.svh]
// Constants of the axis command decoder: frame layout, command codes, status codes, reset values
`ifndef AMP_DEFS_SVH
`define AMP_DEFS_SVH
`define AMP_FRAME_LAST 4'h8
`define AMP_MODULE_ADDR 8'h01
`define move_to_position_cmd 8'h04
`define write_axis_param_cmd 8'h05
`define read_axis_param_cmd 8'h06
`define save_axis_param_cmd 8'h07
`define reload_axis_param_cmd 8'h08
`define absolute_move_type 8'h00
`define relative_move_type 8'h01
`define stored_move_type_a 8'h02
`define AMP_PAR_TARGET 4'h0
`define AMP_PAR_ACTUAL 8'h01
`define AMP_PAR_MAXSPD 4'h4
`define AMP_PARAM_CNT 8'h10
`define AMP_BOOT_LAST 4'hf
`define AMP_ST_OK 8'h64
`define AMP_ST_BAD_CSUM 8'h01
`define AMP_ST_BAD_INS 8'h02
`define AMP_ST_BAD_TYPE 8'h03
`define AMP_NV_DEFAULT 32'h00000000
`define AMP_ZERO32 32'h00000000
`endif

// [amp_pkg.sv]
// Types shared by the axis command decoder and its parameter store
package amp_pkg;
  typedef enum logic [1:0] {
    st_boot = 2'b00,
    st_recv = 2'b01,
    st_exec = 2'b10,
    st_reply = 2'b11
  } amp_state_e;

  typedef enum logic [1:0] {
    pop_none = 2'b00,
    pop_write = 2'b01,
    pop_save = 2'b10,
    pop_reload = 2'b11
  } amp_pop_e;

  typedef struct packed {
    amp_pop_e op;
    logic [3:0] idx;
    logic [31:0] data;
  } amp_preq_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] instr;
    logic [31:0] value;
  } amp_reply_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] instr;
    logic [7:0] ptype;
    logic [7:0] bank;
    logic [31:0] value;
  } amp_frame_s;

  typedef struct packed {
    logic [15:0][31:0] work;
    logic [15:0][31:0] nv;
  } amp_store_s;

  typedef struct packed {
    amp_state_e state;
    logic [3:0] cnt;
    logic [7:0] sum;
    logic csum_bad;
    logic [3:0] boot_idx;
    amp_frame_s frame;
    amp_reply_s reply;
    logic [31:0] accum;
    logic [31:0] target;
    logic move_start;
  } amp_dec_s;
endpackage

// [amp_param_store.sv]
// Axis parameter store: working copy plus non-volatile copy
`timescale 1ns/1ns
`include "amp_defs.svh"
module amp_param_store (
  input wire logic mclk,
  input wire logic reset,
  input amp_pkg::amp_preq_s req,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [31:0] max_pos_speed
);
  amp_pkg::amp_store_s s_reg;
  amp_pkg::amp_store_s s_next;
  logic [31:0] sel_work;
  logic [31:0] sel_nv;

  assign sel_work = s_reg.work[req.idx];
  assign sel_nv = s_reg.nv[req.idx];
  assign rd_data = s_reg.work[rd_idx];
  assign max_pos_speed = s_reg.work[`AMP_PAR_MAXSPD];

  always_comb begin
    s_next = s_reg;
    unique case (req.op)
      amp_pkg::pop_none: ;
      amp_pkg::pop_write: s_next.work[req.idx] = req.data;
      amp_pkg::pop_save: s_next.nv[req.idx] = s_reg.work[req.idx];
      amp_pkg::pop_reload: s_next.work[req.idx] = s_reg.nv[req.idx];
    endcase
  end

  // Reset stands for power-up: the working copy is volatile and starts cleared
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg.work <= '0;
      s_reg.nv <= {16{`AMP_NV_DEFAULT}};
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_write_stores: assert property (
    req.op == amp_pkg::pop_write |=> s_reg.work[$past(req.idx)] == $past(req.data))
    else $error("parameter write not stored");
  a_maxspd_follows: assert property (
    req.op == amp_pkg::pop_write && req.idx == `AMP_PAR_MAXSPD |=> max_pos_speed == $past(req.data))
    else $error("max speed not updated");
  a_save_copies: assert property (
    req.op == amp_pkg::pop_save |=> s_reg.nv[$past(req.idx)] == $past(sel_work))
    else $error("save did not reach non-volatile copy");
  a_reload_copies: assert property (
    req.op == amp_pkg::pop_reload |=> s_reg.work[$past(req.idx)] == $past(sel_nv))
    else $error("reload did not restore working copy");
endmodule

// [amp_cmd_decoder.sv]
// Axis command decoder: nine-byte frame receiver, command execution and reply
// Summary of operation
// - Frame is address, instruction, type, bank, value MSB first, checksum.
// - Move type 1 adds signed value to actual position as new target.
// - Move type 2 moves to the stored coordinate numbered by value.
// - Instruction 5 writes value into the selected volatile axis parameter.
// - Axis parameter 4 is the maximum positioning speed.
// - Instruction 6 returns the selected parameter with status 100.
// - In standalone mode a parameter read also loads the accumulator.
// - In direct mode a parameter read leaves the accumulator unchanged.
// - Axis parameter 1 reads back the actual position.
// - Instruction 7 saves the parameter to non-volatile copy, replies 100, zero.
// - Instruction 8 reloads the parameter from the non-volatile copy, replies 100.
// - After power-up every axis parameter loads from its non-volatile copy.
// - Move type 0 takes value as absolute signed 32-bit target.
// - Moves reply right after starting, without waiting for arrival.
`timescale 1ns/1ns
`include "amp_defs.svh"
module amp_cmd_decoder (
  input wire logic mclk,
  input wire logic reset,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic standalone_mode,
  input wire logic [31:0] actual_position,
  output logic [7:0] stored_move_type_a_idx,
  input wire logic [31:0] stored_move_type_a_data,
  output logic reply_valid,
  input wire logic reply_ready,
  output amp_pkg::amp_reply_s reply,
  output logic [31:0] target_position,
  output logic move_start,
  output logic [31:0] max_pos_speed,
  output logic [31:0] accumulator
);
  amp_pkg::amp_dec_s s_reg;
  amp_pkg::amp_dec_s s_next;
  amp_pkg::amp_preq_s preq;
  logic [31:0] rd_data;
  logic [31:0] read_val;
  logic type_ok;
  logic exec_ok;

  amp_param_store u_store (
    .mclk(mclk),
    .reset(reset),
    .req(preq),
    .rd_idx(s_reg.frame.ptype[3:0]),
    .rd_data(rd_data),
    .max_pos_speed(max_pos_speed)
  );

  assign rx_ready = (s_reg.state == amp_pkg::st_recv);
  assign reply_valid = (s_reg.state == amp_pkg::st_reply);
  assign reply = s_reg.reply;
  assign target_position = s_reg.target;
  assign move_start = s_reg.move_start;
  assign accumulator = s_reg.accum;
  // Coordinate table lives outside; it answers in the same cycle
  assign stored_move_type_a_idx = s_reg.frame.value[7:0];
  assign type_ok = (s_reg.frame.ptype < `AMP_PARAM_CNT);
  assign read_val = (s_reg.frame.ptype == `AMP_PAR_ACTUAL) ? actual_position : rd_data;
  assign exec_ok = (s_reg.state == amp_pkg::st_exec) && !s_reg.csum_bad;

  always_comb begin
    s_next = s_reg;
    s_next.move_start = 1'b0;
    preq.op = amp_pkg::pop_none;
    preq.idx = s_reg.frame.ptype[3:0];
    preq.data = s_reg.frame.value;
    unique case (s_reg.state)
      amp_pkg::st_boot: begin
        preq.op = amp_pkg::pop_reload;
        preq.idx = s_reg.boot_idx;
        s_next.boot_idx = s_reg.boot_idx + 4'h1;
        if (s_reg.boot_idx == `AMP_BOOT_LAST) begin
          s_next.state = amp_pkg::st_recv;
        end
      end
      amp_pkg::st_recv: begin
        if (rx_valid) begin
          if (s_reg.cnt == `AMP_FRAME_LAST) begin
            // Frames for another address are dropped silently, as on a shared bus
            s_next.csum_bad = (rx_data != s_reg.sum);
            s_next.cnt = 4'h0;
            s_next.sum = 8'h00;
            if (s_reg.frame.addr == `AMP_MODULE_ADDR) begin
              s_next.state = amp_pkg::st_exec;
            end
          end else begin
            s_next.frame = amp_pkg::amp_frame_s'({s_reg.frame[55:0], rx_data});
            s_next.sum = s_reg.sum + rx_data;
            s_next.cnt = s_reg.cnt + 4'h1;
          end
        end
      end
      amp_pkg::st_exec: begin
        s_next.state = amp_pkg::st_reply;
        s_next.reply.status = `AMP_ST_OK;
        s_next.reply.instr = s_reg.frame.instr;
        s_next.reply.value = `AMP_ZERO32;
        if (s_reg.csum_bad) begin
          s_next.reply.status = `AMP_ST_BAD_CSUM;
        end else begin
          unique case (s_reg.frame.instr)
            `move_to_position_cmd: begin
              s_next.move_start = 1'b1;
              preq.op = amp_pkg::pop_write;
              preq.idx = `AMP_PAR_TARGET;
              unique case (s_reg.frame.ptype)
                `absolute_move_type: preq.data = s_reg.frame.value;
                `relative_move_type: preq.data = actual_position + s_reg.frame.value;
                `stored_move_type_a: preq.data = stored_move_type_a_data;
                default: begin
                  s_next.move_start = 1'b0;
                  preq.op = amp_pkg::pop_none;
                  s_next.reply.status = `AMP_ST_BAD_TYPE;
                end
              endcase
              if (s_next.move_start) begin
                s_next.target = preq.data;
              end
            end
            `write_axis_param_cmd: begin
              if (type_ok) begin
                preq.op = amp_pkg::pop_write;
              end else begin
                s_next.reply.status = `AMP_ST_BAD_TYPE;
              end
            end
            `read_axis_param_cmd: begin
              if (type_ok || s_reg.frame.ptype == `AMP_PAR_ACTUAL) begin
                s_next.reply.value = read_val;
                if (standalone_mode) begin
                  s_next.accum = read_val;
                end
                // Direct mode leaves the accumulator alone
              end else begin
                s_next.reply.status = `AMP_ST_BAD_TYPE;
              end
            end
            `save_axis_param_cmd, `reload_axis_param_cmd: begin
              // The value field is ignored; the reply value stays zero
              if (!type_ok) begin
                s_next.reply.status = `AMP_ST_BAD_TYPE;
              end else if (s_reg.frame.instr == `save_axis_param_cmd) begin
                preq.op = amp_pkg::pop_save;
              end else begin
                preq.op = amp_pkg::pop_reload;
              end
            end
            default: s_next.reply.status = `AMP_ST_BAD_INS;
          endcase
        end
      end
      amp_pkg::st_reply: begin
        // Receiver is stalled while the reply waits, so no frame overruns it
        if (reply_ready) begin
          s_next.state = amp_pkg::st_recv;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.state <= amp_pkg::st_boot;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_boot_reload_all: assert property (
    $past(reset) && !reset |-> s_reg.state == amp_pkg::st_boot ##16 s_reg.state == amp_pkg::st_recv)
    else $error("boot reload did not take sixteen cycles");
  a_move_nonblock: assert property (
    exec_ok && s_reg.frame.instr == `move_to_position_cmd && s_reg.frame.ptype <= `stored_move_type_a
    |=> move_start && reply_valid && reply.status == `AMP_ST_OK)
    else $error("move did not start and reply at once");
  a_abs_target: assert property (
    exec_ok && s_reg.frame.instr == `move_to_position_cmd && s_reg.frame.ptype == `absolute_move_type
    |=> target_position == $past(s_reg.frame.value))
    else $error("absolute target wrong");
  a_rel_target: assert property (
    exec_ok && s_reg.frame.instr == `move_to_position_cmd && s_reg.frame.ptype == `relative_move_type
    |=> target_position == $past(actual_position) + $past(s_reg.frame.value))
    else $error("relative target wrong");
  a_stored_move_type_a_target: assert property (
    exec_ok && s_reg.frame.instr == `move_to_position_cmd && s_reg.frame.ptype == `stored_move_type_a
    |=> target_position == $past(stored_move_type_a_data))
    else $error("coordinate target wrong");
  a_read_actual: assert property (
    exec_ok && s_reg.frame.instr == `read_axis_param_cmd && s_reg.frame.ptype == `AMP_PAR_ACTUAL
    |=> reply.value == $past(actual_position) && reply.status == `AMP_ST_OK)
    else $error("actual position read wrong");
  a_read_reply: assert property (
    exec_ok && s_reg.frame.instr == `read_axis_param_cmd && type_ok
    |=> reply_valid && reply.value == $past(read_val) && reply.status == `AMP_ST_OK)
    else $error("parameter read reply wrong");
  a_accum_load: assert property (
    exec_ok && s_reg.frame.instr == `read_axis_param_cmd && type_ok && standalone_mode
    |=> accumulator == reply.value)
    else $error("accumulator not loaded");
  a_accum_keep: assert property (
    exec_ok && s_reg.frame.instr == `read_axis_param_cmd && !standalone_mode |=> $stable(accumulator))
    else $error("accumulator changed in direct mode");
  a_save_reply: assert property (
    exec_ok && s_reg.frame.instr == `save_axis_param_cmd && type_ok
    |=> reply.status == `AMP_ST_OK && reply.value == `AMP_ZERO32)
    else $error("save reply wrong");
  a_bad_csum: assert property (
    s_reg.state == amp_pkg::st_exec && s_reg.csum_bad
    |-> preq.op == amp_pkg::pop_none ##1 reply.status == `AMP_ST_BAD_CSUM && !move_start)
    else $error("bad checksum frame not rejected");
endmodule

// [amp_host_model.sv]
// Host controller model: sends command frames and takes replies
`timescale 1ns/1ns
module amp_host_model (
  input wire logic mclk,
  input wire logic go,
  input amp_pkg::amp_frame_s frm,
  input wire logic [7:0] flip,
  input wire logic [3:0] stall,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic reply_valid,
  output logic reply_ready,
  input amp_pkg::amp_reply_s reply,
  input wire logic move_start,
  output amp_pkg::amp_reply_s got,
  output logic got_move,
  output logic [7:0] n_done
);
  logic [7:0] b [0:8];
  logic [7:0] sum;
  logic ok;
  logic hit;
  // Drives on the falling edge, samples the decoder on the rising edge
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    reply_ready = 1'b0;
    got = '0;
    got_move = 1'b0;
    n_done = 8'h00;
    forever begin
      @(posedge mclk);
      if (go) begin
        {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = frm;
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum = sum + b[i];
        b[8] = sum ^ flip;
        ok = 1'b1;
        for (int i = 0; i < 9; i++) begin
          @(negedge mclk);
          rx_valid = 1'b1;
          rx_data = b[i];
          hit = 1'b0;
          // Byte holds until the edge that finds the decoder ready
          for (int k = 0; k < 20 && !hit; k++) begin
            @(posedge mclk);
            hit = (rx_ready === 1'b1);
          end
          ok = ok & hit;
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        // Released line shows the inverse so a stale byte cannot pass
        rx_data = ~b[8];
        // Only our own module address answers
        if (frm.addr == 8'h01) begin
          hit = 1'b0;
          for (int k = 0; k < 50 && !hit; k++) begin
            @(posedge mclk);
            hit = (reply_valid === 1'b1);
          end
          got_move = move_start;
          ok = ok & hit;
          repeat (stall) @(posedge mclk);
          @(negedge mclk);
          reply_ready = 1'b1;
          @(posedge mclk);
          got = reply;
          @(negedge mclk);
          reply_ready = 1'b0;
        end
        // A lost byte or reply leaves the count alone, so the bench times out
        @(posedge mclk);
        if (ok) n_done = n_done + 8'h01;
      end
    end
  end
endmodule

// [tb_amp_cmd_decoder.sv]
// Testbench of the axis command decoder against a host model
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_amp_cmd_decoder;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic sa = 1'b0;
  logic rxv, rxr, rv, rr, ms, gm;
  logic [7:0] rxd, nd, ci;
  logic [7:0] flip = 8'h00;
  logic [7:0] adr = 8'h01;
  logic [3:0] stall = 4'h0;
  logic [31:0] act = 32'h0;
  logic [31:0] cd, tp, mps, acc;
  amp_pkg::amp_frame_s frm = '0;
  amp_pkg::amp_reply_s rep, got;
  int n_fail = 0;
  int n_checks = 0;
  always #10 mclk = ~mclk;
  // Coordinate table: entry n reads 32'h00100000 with n in the low byte
  assign cd = 32'h00100000 | {24'h0, ci};
  amp_cmd_decoder dut (.mclk(mclk), .reset(reset), .rx_valid(rxv), .rx_data(rxd), .rx_ready(rxr),
    .standalone_mode(sa), .actual_position(act), .stored_move_type_a_idx(ci), .stored_move_type_a_data(cd), .reply_valid(rv),
    .reply_ready(rr), .reply(rep), .target_position(tp), .move_start(ms), .max_pos_speed(mps),
    .accumulator(acc));
  amp_host_model host (.mclk(mclk), .go(go), .frm(frm), .flip(flip), .stall(stall), .rx_ready(rxr),
    .rx_valid(rxv), .rx_data(rxd), .reply_valid(rv), .reply_ready(rr), .reply(rep), .move_start(ms),
    .got(got), .got_move(gm), .n_done(nd));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] i, t, input logic [31:0] v, input logic [7:0] es, input logic [31:0] ev);
    logic [7:0] n0;
    n0 = nd;
    frm = '{adr, i, t, 8'h00, v};
    go = 1'b1;
    @(negedge mclk) go = 1'b0;
    for (int k = 0; k < 200 && nd == n0; k++) @(negedge mclk);
    if (nd == n0) begin
      n_fail++;
      report_and_stop;
    end else if (adr == 8'h01) begin
      `CHK("status", es, got.status)
      `CHK("value", ev, got.value)
      `CHK("instr", i, got.instr)
    end
  endtask
  task automatic t_boot;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    repeat (15) @(negedge mclk);
    `CHK("boot busy", 1'b0, rxr)
    @(negedge mclk) `CHK("boot done", 1'b1, rxr)
    cmd(8'h06, 8'h04, 32'h0, 8'h64, 32'h0);
    $display("test boot done");
  endtask
  task automatic t_param;
    cmd(8'h05, 8'h04, 32'h3e8, 8'h64, 32'h0);
    `CHK("speed", 32'h3e8, mps)
    `CHK("no move", 1'b0, gm)
    cmd(8'h06, 8'h04, 32'h0, 8'h64, 32'h3e8);
    cmd(8'h0a, 8'h00, 32'h0, 8'h02, 32'h0);
    cmd(8'h05, 8'h20, 32'h1, 8'h03, 32'h0);
    $display("test param done");
  endtask
  task automatic t_pos;
    act = 32'h2710;
    sa = 1'b1;
    cmd(8'h06, 8'h04, 32'h0, 8'h64, 32'h3e8);
    `CHK("acc prog", 32'h3e8, acc)
    sa = 1'b0;
    cmd(8'h06, 8'h01, 32'h0, 8'h64, 32'h2710);
    `CHK("acc direct", 32'h3e8, acc)
    $display("test pos done");
  endtask
  task automatic t_move;
    act = 32'hc350;
    cmd(8'h04, 8'h00, 32'h15f90, 8'h64, 32'h0);
    `CHK("abs", 32'h15f90, tp)
    `CHK("pulse", 1'b1, gm)
    // Offset keeps the travel far inside the signed range
    cmd(8'h04, 8'h01, 32'hffffd8f0, 8'h64, 32'h0);
    `CHK("rel", 32'h9c40, tp)
    cmd(8'h04, 8'h02, 32'h8, 8'h64, 32'h0);
    `CHK("stored_move_type_a", 32'h100008, tp)
    cmd(8'h06, 8'h00, 32'h0, 8'h64, 32'h100008);
    // Unknown move type must be refused without moving
    cmd(8'h04, 8'h03, 32'h5, 8'h03, 32'h0);
    `CHK("bad move target", 32'h100008, tp)
    `CHK("bad move pulse", 1'b0, gm)
    $display("test move done");
  endtask
  task automatic t_nv;
    stall = 4'h3;
    cmd(8'h05, 8'h06, 32'h55, 8'h64, 32'h0);
    cmd(8'h07, 8'h06, 32'h1234, 8'h64, 32'h0);
    cmd(8'h05, 8'h06, 32'h77, 8'h64, 32'h0);
    cmd(8'h06, 8'h06, 32'h0, 8'h64, 32'h77);
    cmd(8'h08, 8'h06, 32'h99, 8'h64, 32'h0);
    cmd(8'h06, 8'h06, 32'h0, 8'h64, 32'h55);
    cmd(8'h07, 8'h10, 32'h0, 8'h03, 32'h0);
    stall = 4'h0;
    $display("test nv done");
  endtask
  task automatic t_frame;
    flip = 8'h01;
    cmd(8'h05, 8'h04, 32'h5, 8'h01, 32'h0);
    flip = 8'h00;
    cmd(8'h06, 8'h04, 32'h0, 8'h64, 32'h3e8);
    adr = 8'h02;
    cmd(8'h05, 8'h04, 32'h7, 8'h64, 32'h0);
    adr = 8'h01;
    repeat (4) begin
      @(negedge mclk) `CHK("no reply", 1'b0, rv)
    end
    cmd(8'h06, 8'h04, 32'h0, 8'h64, 32'h3e8);
    $display("test frame done");
  endtask
  initial begin
    t_boot;
    t_param;
    t_pos;
    t_move;
    t_nv;
    t_frame;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    report_and_stop;
  end
endmodule
